//--- dv/lowpower_timer_compare_wakeup_tb.sv
// self-checking bench joining the timer end and the host end
`timescale 1ns/1ps
module lowpower_timer_compare_wakeup_tb
  import lpw_pkg::*;
();
  typedef struct packed {
    logic        w;
    logic [31:0] a;
    logic [15:0] d;
    logic        e;
    logic [15:0] r;
  } lpw_row_t;
  localparam logic [31:0] CA = CMP_ZERO_ADDR;
  localparam logic [31:0] WA = WAKE_CTRL_ADDR;
  localparam logic [31:0] UA = 32'h0008_00c0;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        cmd_valid = 1'h0;
  logic        cmd_write = 1'h0;
  logic [31:0] cmd_addr = 32'h0000_0000;
  logic [15:0] cmd_wdata = 16'h0000;
  logic        run = 1'h0;
  logic [15:0] period = 16'h0005;
  logic        stby_req = 1'h0;
  logic        done, err, standby, wake, match, wake_en;
  logic        ready, blocked, wrap;
  logic [15:0] rdata, count, cmp, n, prev;
  int          errors = 0;
  int          tests_run = 0;
  lpw_row_t    rows [10] = '{
    '{1'h1, CA, 16'h0004, 1'h0, 16'h0000},
    '{1'h0, CA, 16'h0000, 1'h0, 16'h0004},
    '{1'h1, CA, 16'h0005, 1'h1, 16'h0000},
    '{1'h0, CA, 16'h0000, 1'h0, 16'h0004},
    '{1'h1, WA, 16'hffff, 1'h0, 16'h0000},
    '{1'h0, WA, 16'h0000, 1'h0, 16'h8000},
    '{1'h1, UA, 16'h1234, 1'h0, 16'h0000},
    '{1'h0, UA, 16'h0000, 1'h0, 16'h0000},
    '{1'h0, CA, 16'h0000, 1'h0, 16'h0004},
    '{1'h1, CA, 16'h0002, 1'h0, 16'h0000}
  };
  lpw_if link ();
  lpw_timer_dev lpw_timer_dev_i (.LINK(link), .I_CLK(clk), .I_RST(rst), .O_COUNT(count),
    .O_CMP(cmp), .O_WAKE_EN(wake_en), .O_MATCH(match), .O_WRAP(wrap),
    .O_WR_BLOCKED(blocked));
  lpw_host_end lpw_host_end_i (.LINK(link), .I_CLK(clk), .I_RST(rst),
    .I_CMD_VALID(cmd_valid),
    .I_CMD_WRITE(cmd_write), .I_CMD_ADDR(cmd_addr), .I_CMD_WDATA(cmd_wdata), .I_RUN(run),
    .I_PERIOD(period), .I_STANDBY_REQ(stby_req), .O_CMD_READY(ready), .O_CMD_DONE(done),
    .O_CMD_ERR(err), .O_CMD_RDATA(rdata), .O_STANDBY(standby), .O_WAKE(wake));
  lpw_asserts lpw_asserts_i (.I_CLK(clk), .I_RST(rst), .reg_addr(link.reg_addr),
    .reg_wr(link.reg_wr), .reg_rd(link.reg_rd), .reg_wdata(link.reg_wdata),
    .reg_rdata(link.reg_rdata), .reg_rvalid(link.reg_rvalid), .prot_en(link.prot_en),
    .count_run(link.count_run), .period_setting(link.period_setting),
    .in_standby(link.in_standby), .wake_event(link.wake_event),
    .count_value(link.count_value));
  always #2.5 clk = ~clk;
  task automatic check(input string s, input logic [15:0] seen, input logic [15:0] exp);
    tests_run++;
    if (seen !== exp) begin
      errors++;
      $display("CHECK FAILED %s expected %h seen %h", s, exp, seen);
    end
  endtask : check
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask : wrap_up
  task automatic cmd(input lpw_row_t r);
    int k;
    k = 0;
    cmd_valid = 1'h1;
    cmd_write = r.w;
    cmd_addr = r.a;
    cmd_wdata = r.d;
    @(negedge clk);
    cmd_valid = 1'h0;
    check("ready taken", 16'(ready), 16'(r.e));
    while (done !== 1'h1 && k < 8) begin
      @(negedge clk);
      k++;
    end
    if (k == 8) begin
      check("done wait", 16'h0001, 16'h0000);
      wrap_up();
    end
    check("error flag", 16'(err), 16'(r.e));
    check("blocked", 16'(blocked), 16'h0000);
    check("ready idle", 16'(ready), 16'h0001);
    if (!r.w) check("read data", rdata, r.r);
    @(negedge clk);
  endtask : cmd
  initial begin
    repeat (6) @(negedge clk);
    rst = 1'h0;
    @(negedge clk);
    foreach (rows[i]) cmd(rows[i]);
    $display("test registers done");
    run = 1'h1;
    repeat (4) @(negedge clk);
    prev = count;
    n = 16'h0000;
    for (int i = 0; i < 12; i++) begin
      @(negedge clk);
      check("count", count, (prev == 16'h0005) ? 16'h0000 : prev + 16'h0001);
      prev = count;
      if (match === 1'h1) n++;
      if (wrap === 1'h1) n = n + 16'h0010;
      if (wake === 1'h1) n = n + 16'h0100;
    end
    check("matches", n, 16'h0022);
    cmd('{1'h1, CA, 16'h0001, 1'h1, 16'h0000});
    $display("test counting done");
    stby_req = 1'h1;
    @(negedge clk);
    stby_req = 1'h0;
    n = 16'h0000;
    while (wake !== 1'h1 && n < 16'h0014) begin
      @(negedge clk);
      n++;
    end
    check("wake seen", 16'(wake), 16'h0001);
    check("standby left", 16'(standby), 16'h0000);
    @(negedge clk);
    check("wake pulse", 16'(wake), 16'h0000);
    $display("test wakeup done");
    run = 1'h0;
    repeat (2) @(negedge clk);
    cmd('{1'h1, WA, 16'h0000, 1'h0, 16'h0000});
    run = 1'h1;
    stby_req = 1'h1;
    @(negedge clk);
    stby_req = 1'h0;
    n = 16'h0000;
    repeat (16) begin
      @(negedge clk);
      if (wake === 1'h1) n++;
    end
    check("no wake", n, 16'h0000);
    check("still standby", 16'(standby), 16'h0001);
    $display("test wake disabled done");
    rst = 1'h1;
    run = 1'h0;
    @(negedge clk);
    check("count reset", count, COUNT_RST);
    check("compare reset", cmp, CMP_ZERO_RST);
    check("enable reset", 16'(wake_en), 16'(WAKE_EN_RST));
    check("standby reset", 16'(standby), 16'h0000);
    rst = 1'h0;
    $display("test reset done");
    wrap_up();
  end
endmodule : lowpower_timer_compare_wakeup_tb

//--- dv/lpw_asserts.sv
// link assertions for the timer end and the host end
`timescale 1ns/1ps
module lpw_asserts
  import lpw_pkg::*;
(
  input wire logic        I_CLK,
  input wire logic        I_RST,
  input wire logic [31:0] reg_addr,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [15:0] reg_wdata,
  input wire logic [15:0] reg_rdata,
  input wire logic        reg_rvalid,
  input wire logic        prot_en,
  input wire logic        count_run,
  input wire logic [15:0] period_setting,
  input wire logic        in_standby,
  input wire logic        wake_event,
  input wire logic [15:0] count_value
);
  logic [15:0] cmp_q;
  logic        wen_q;
  wire         wr_ok = reg_wr && prot_en;
  wire         at_c  = reg_addr == CMP_ZERO_ADDR;
  wire         at_w  = reg_addr == WAKE_CTRL_ADDR;
  wire         at_p  = count_value == period_setting;
  wire         hit   = count_run && count_value == cmp_q && wen_q && in_standby;
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cmp_q <= CMP_ZERO_RST;
      wen_q <= WAKE_EN_RST;
    end else begin
      if (wr_ok && at_c) cmp_q <= reg_wdata;
      if (wr_ok && at_w) wen_q <= reg_wdata[WAKE_EN_BIT];
    end
  end
  default clocking cb @(posedge I_CLK); endclocking
  default disable iff (I_RST);
  sequence s_open;
    prot_en ##1 reg_wr && prot_en;
  endsequence
  sequence s_shut;
    !reg_wr && !prot_en;
  endsequence
  a_prot_walk: assert property ($rose(prot_en) |-> s_open ##1 s_shut)
    else $error("write window malformed");
  a_wr_stopped: assert property (reg_wr |-> prot_en && !count_run)
    else $error("write while running");
  a_cmp_below: assert property (reg_wr && at_c |-> reg_wdata < period_setting)
    else $error("compare not below period");
  a_rsvd_wr: assert property (reg_wr && at_w |-> reg_wdata[14:0] == WAKE_RSVD_ZERO)
    else $error("reserved bits written nonzero");
  a_rsvd_rd: assert property (reg_rd && at_w |=> reg_rvalid &&
      reg_rdata == {wen_q, WAKE_RSVD_ZERO})
    else $error("wake control read wrong");
  a_cmp_rd: assert property (reg_rd && at_c |=> reg_rvalid && reg_rdata == cmp_q)
    else $error("compare read wrong");
  a_count_step: assert property (count_run && !at_p |=>
      count_value == $past(count_value) + COUNT_STEP)
    else $error("counter did not step");
  a_count_wrap: assert property (count_run && at_p |=> count_value == COUNT_RST)
    else $error("counter did not wrap");
  a_count_hold: assert property (!count_run |=> $stable(count_value))
    else $error("stopped counter moved");
  a_wake_fire: assert property (hit |=> wake_event)
    else $error("wake event missing");
  a_wake_cause: assert property (wake_event |-> $past(hit))
    else $error("wake event without cause");
  a_wake_pulse: assert property (wake_event |=> !wake_event)
    else $error("wake event too long");
endmodule : lpw_asserts

//--- src/lpw_host_end.sv
// software and standby end: register writes under protect, run, period, standby
`timescale 1ns/1ps
module lpw_host_end
  import lpw_pkg::*;
(
  lpw_if.host         LINK,
  input  wire logic   I_CLK,
  input  wire logic   I_RST,
  input  wire logic        I_CMD_VALID,
  input  wire logic        I_CMD_WRITE,
  input  wire logic [31:0] I_CMD_ADDR,
  input  wire logic [15:0] I_CMD_WDATA,
  input  wire logic        I_RUN,
  input  wire logic [15:0] I_PERIOD,
  input  wire logic        I_STANDBY_REQ,
  output logic        O_CMD_READY,
  output logic        O_CMD_DONE,
  output logic        O_CMD_ERR,
  output logic [15:0] O_CMD_RDATA,
  output logic        O_STANDBY,
  output logic        O_WAKE
);

  lpw_host_state_t state_q;
  lpw_host_state_t state_d;
  logic [31:0] addr_q;
  logic [15:0] wdata_q;
  logic        wr_q;
  logic        rd_q;
  logic        prot_q;
  logic        run_q;
  logic [15:0] period_q;
  logic        standby_q;
  logic        wake_q;
  logic        ready_q;
  logic        done_q;
  logic        err_q;
  logic [15:0] rdata_q;

  wire         is_cmp;
  wire         is_wake;
  wire         cmp_too_big;
  wire         wr_illegal;
  wire [15:0]  wdata_clean;
  wire         take;

  assign take        = (state_q == HS_IDLE) & I_CMD_VALID;
  assign is_cmp      = (I_CMD_ADDR == CMP_ZERO_ADDR);
  assign is_wake     = (I_CMD_ADDR == WAKE_CTRL_ADDR);
  assign cmp_too_big = is_cmp & (I_CMD_WDATA >= period_q);
  // registers are left alone while the counter is running
  assign wr_illegal  = run_q | cmp_too_big;
  assign wdata_clean = is_wake ? {I_CMD_WDATA[WAKE_EN_BIT], WAKE_RSVD_ZERO}
                               : I_CMD_WDATA;

  always_comb begin
    state_d = state_q;
    case (state_q)
      HS_IDLE: begin
        if (take && I_CMD_WRITE && !wr_illegal) begin
          state_d = HS_PROT;
        end else if (take && !I_CMD_WRITE) begin
          state_d = HS_READ;
        end
      end
      HS_PROT:  state_d = HS_WRITE;
      HS_WRITE: state_d = HS_IDLE;
      HS_READ:  state_d = HS_WAIT;
      HS_WAIT: begin
        if (LINK.reg_rvalid) begin
          state_d = HS_IDLE;
        end
      end
      default:  state_d = HS_IDLE;
    endcase
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      state_q <= HS_IDLE;
      addr_q  <= 32'h0000_0000;
      wdata_q <= DATA_ZERO;
      ready_q <= 1'b1;
    end else begin
      state_q <= state_d;
      ready_q <= (state_d == HS_IDLE);
      if (take) begin
        addr_q  <= I_CMD_ADDR;
        wdata_q <= wdata_clean;
      end
    end
  end

  // protect bit rises one clock before the write and falls after it
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      prot_q <= 1'b0;
      wr_q   <= 1'b0;
      rd_q   <= 1'b0;
    end else begin
      prot_q <= (state_d == HS_PROT) | (state_d == HS_WRITE);
      wr_q   <= (state_d == HS_WRITE);
      rd_q   <= (state_d == HS_READ);
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      done_q  <= 1'b0;
      err_q   <= 1'b0;
      rdata_q <= DATA_ZERO;
    end else begin
      done_q <= (take && I_CMD_WRITE && wr_illegal) || (state_q == HS_WRITE)
                || ((state_q == HS_WAIT) && LINK.reg_rvalid);
      err_q  <= take & I_CMD_WRITE & wr_illegal;
      if ((state_q == HS_WAIT) && LINK.reg_rvalid) begin
        rdata_q <= LINK.reg_rdata;
      end
    end
  end

  // run, period and standby state; a wake event ends standby
  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      run_q     <= 1'b0;
      period_q  <= PERIOD_RST;
      standby_q <= 1'b0;
      wake_q    <= 1'b0;
    end else begin
      wake_q <= standby_q & LINK.wake_event;
      // run and period move only between commands, so a write in flight sees them fixed
      if (state_d == HS_IDLE) begin
        run_q <= I_RUN;
        if (!run_q) begin
          period_q <= I_PERIOD;
        end
      end
      if (standby_q && LINK.wake_event) begin
        standby_q <= 1'b0;
      end else if (I_STANDBY_REQ) begin
        standby_q <= 1'b1;
      end
    end
  end

  assign LINK.reg_addr       = addr_q;
  assign LINK.reg_wdata      = wdata_q;
  assign LINK.reg_wr         = wr_q;
  assign LINK.reg_rd         = rd_q;
  assign LINK.prot_en        = prot_q;
  assign LINK.count_run      = run_q;
  assign LINK.period_setting = period_q;
  assign LINK.in_standby     = standby_q;

  assign O_CMD_READY = ready_q;
  assign O_CMD_DONE  = done_q;
  assign O_CMD_ERR   = err_q;
  assign O_CMD_RDATA = rdata_q;
  assign O_STANDBY   = standby_q;
  assign O_WAKE      = wake_q;

endmodule : lpw_host_end

//--- src/lpw_if.sv
// link between the timer compare end and the software/standby end
`timescale 1ns/1ps
interface lpw_if;
  import lpw_pkg::*;

  logic [31:0] reg_addr;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_wdata;
  logic [15:0] reg_rdata;
  logic        reg_rvalid;
  logic        prot_en;
  logic        count_run;
  logic [15:0] period_setting;
  logic        in_standby;
  logic        wake_event;
  logic [15:0] count_value;

  modport dev (
    input  reg_addr,
    input  reg_wr,
    input  reg_rd,
    input  reg_wdata,
    output reg_rdata,
    output reg_rvalid,
    input  prot_en,
    input  count_run,
    input  period_setting,
    input  in_standby,
    output wake_event,
    output count_value
  );

  modport host (
    output reg_addr,
    output reg_wr,
    output reg_rd,
    output reg_wdata,
    input  reg_rdata,
    input  reg_rvalid,
    output prot_en,
    output count_run,
    output period_setting,
    output in_standby,
    input  wake_event,
    input  count_value
  );

endinterface : lpw_if

//--- src/lpw_pkg.sv
// shared constants and types for the low-power timer compare and wakeup ends
package lpw_pkg;

  localparam int unsigned ADDR_W = 32;
  localparam int unsigned DATA_W = 16;

  // register byte addresses
  localparam logic [31:0] CMP_ZERO_ADDR   = 32'h0008_00b8;
  localparam logic [31:0] WAKE_CTRL_ADDR  = 32'h0008_00bc;

  // field positions
  localparam int unsigned WAKE_EN_BIT     = 15;

  // values after reset, plus the reserved-bit zero and the count step
  localparam logic [15:0] CMP_ZERO_RST    = 16'h0000;
  localparam logic        WAKE_EN_RST     = 1'b0;
  localparam logic [15:0] COUNT_RST       = 16'h0000;
  localparam logic [15:0] PERIOD_RST      = 16'hffff;
  localparam logic [15:0] DATA_ZERO       = 16'h0000;
  localparam logic [14:0] WAKE_RSVD_ZERO  = 15'h0000;
  localparam logic [15:0] COUNT_STEP      = 16'h0001;

  // host command sequencer
  typedef enum logic [2:0] {
    HS_IDLE   = 3'b000,
    HS_PROT   = 3'b001,
    HS_WRITE  = 3'b010,
    HS_READ   = 3'b011,
    HS_WAIT   = 3'b100
  } lpw_host_state_t;

endpackage : lpw_pkg

//--- src/lpw_timer_dev.sv
// timer end: counter, compare value, wake control and standby wake event
// Contract
// - continuously compare 16-bit counter with compare value
// - compare value must stay below period
// - compare written only while counter stopped
// - wake control bit 15 enables standby wakeup
// - wake enable changed only while counter stopped
// - wake control bits 14:0 read zero, write zero
// - protect bit set before writing these registers
// - enabled match requests return from standby
// - counter at period wraps to zero next
// - run bit stops or runs the counter
// - match event only while in standby; O_MATCH still pulses outside standby, only the wake event is gated
`timescale 1ns/1ps
module lpw_timer_dev
  import lpw_pkg::*;
(
  lpw_if.dev          LINK,
  input  wire logic   I_CLK,
  input  wire logic   I_RST,
  output logic [15:0] O_COUNT,
  output logic [15:0] O_CMP,
  output logic        O_WAKE_EN,
  output logic        O_MATCH,
  output logic        O_WRAP,
  output logic        O_WR_BLOCKED
);

  // stored state
  logic [15:0] cmp_q;
  logic [15:0] cmp_d;
  logic        wake_en_q;
  logic        wake_en_d;
  logic [15:0] cnt_q;
  logic [15:0] cnt_d;
  logic        evt_q;
  logic        evt_d;
  logic        match_q;
  logic        wrap_q;
  logic        blocked_q;
  logic        blocked_d;
  logic [15:0] rdata_q;
  logic [15:0] rdata_d;
  logic        rvalid_q;

  // address decode
  wire         sel_cmp;
  wire         sel_wake;
  wire         wr_ok;
  wire         cmp_we;
  wire         wake_we;
  wire         rd_hit;

  // counter and compare terms
  wire         running;
  wire         at_period;
  wire         cmp_equal;
  wire         match_now;
  wire [15:0]  cnt_next;
  wire [15:0]  wake_word;

  assign sel_cmp   = (LINK.reg_addr == CMP_ZERO_ADDR);
  assign sel_wake  = (LINK.reg_addr == WAKE_CTRL_ADDR);
  // writes land only while the protect bit is held high
  assign wr_ok     = LINK.reg_wr & LINK.prot_en;
  assign cmp_we    = wr_ok & sel_cmp;
  assign wake_we   = wr_ok & sel_wake;
  assign rd_hit    = LINK.reg_rd & (sel_cmp | sel_wake);

  // reserved bits of the wake control word always read as zero
  assign wake_word = {wake_en_q, WAKE_RSVD_ZERO};

  assign running   = LINK.count_run;
  assign at_period = (cnt_q == LINK.period_setting);
  assign cnt_next  = cnt_q + COUNT_STEP;
  assign cmp_equal = (cnt_q == cmp_q);
  // each counter value lives one clock, so a match is one pulse
  assign match_now = running & cmp_equal;

  // compare value register
  always_comb begin
    cmp_d = cmp_q;
    if (cmp_we) begin
      cmp_d = LINK.reg_wdata;
    end
  end

  // wake enable register, only bit 15 is stored
  always_comb begin
    wake_en_d = wake_en_q;
    if (wake_we) begin
      wake_en_d = LINK.reg_wdata[WAKE_EN_BIT];
    end
  end

  // up-counter with wrap at the period setting
  always_comb begin
    cnt_d = cnt_q;
    if (running) begin
      if (at_period) begin
        cnt_d = COUNT_RST;
      end else begin
        cnt_d = cnt_next;
      end
    end
  end

  // wake event toward the event link unit
  always_comb begin
    evt_d = 1'b0;
    if (match_now && wake_en_q && LINK.in_standby) begin
      evt_d = 1'b1;
    end
  end

  // flag a write attempt that lacked the protect bit
  always_comb begin
    blocked_d = 1'b0;
    if (LINK.reg_wr && !LINK.prot_en && (sel_cmp || sel_wake)) begin
      blocked_d = 1'b1;
    end
  end

  // read data, unmapped addresses return zero
  always_comb begin
    rdata_d = rdata_q;
    if (LINK.reg_rd) begin
      if (sel_cmp) begin
        rdata_d = cmp_q;
      end else if (sel_wake) begin
        rdata_d = wake_word;
      end else begin
        rdata_d = DATA_ZERO;
      end
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cmp_q     <= CMP_ZERO_RST;
      wake_en_q <= WAKE_EN_RST;
    end else begin
      cmp_q     <= cmp_d;
      wake_en_q <= wake_en_d;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      cnt_q   <= COUNT_RST;
      wrap_q  <= 1'b0;
      match_q <= 1'b0;
    end else begin
      cnt_q   <= cnt_d;
      wrap_q  <= running & at_period;
      match_q <= match_now;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      evt_q     <= 1'b0;
      blocked_q <= 1'b0;
    end else begin
      evt_q     <= evt_d;
      blocked_q <= blocked_d;
    end
  end

  always_ff @(posedge I_CLK or posedge I_RST) begin
    if (I_RST) begin
      rdata_q  <= DATA_ZERO;
      rvalid_q <= 1'b0;
    end else begin
      rdata_q  <= rdata_d;
      rvalid_q <= LINK.reg_rd;
    end
  end

  // link side
  assign LINK.reg_rdata   = rdata_q;
  assign LINK.reg_rvalid  = rvalid_q;
  assign LINK.wake_event  = evt_q;
  assign LINK.count_value = cnt_q;

  // user side
  assign O_COUNT      = cnt_q;
  assign O_CMP        = cmp_q;
  assign O_WAKE_EN    = wake_en_q;
  assign O_MATCH      = match_q;
  assign O_WRAP       = wrap_q;
  assign O_WR_BLOCKED = blocked_q;

endmodule : lpw_timer_dev
